// ### hdl/fpec_ctrl.v
// flash program and erase controller with apb registers
// Overview of operation
// R1 - timing clock from aux, sub-main or main
// R2 - hold selected clock running while operation pending; the keep requests drop while suspended, and select 3 raises none
// R3 - emergency exit bit ends operation at once
// R4 - accepted interrupt aborts when enabled and global
// R5 - interrupt pauses erase, return resumes it
// R6 - busy bit reads one while operation active
// R7 - information region 0x1080 to 0x10ff readable
// R8 - main region 0xc000 to 0xffff readable
// R9 - stopped timing clock aborts the operation
// R10 - software waits after exit before flash access
// R11 - software waits 6 us after interrupt abort
// R12 - margin-0 read mode for checksums
// R13 - software avoids low power during operations
// R14 - busy clears with array drive, same cycle
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "fpec_defs.vh"

module fpec_ctrl (
  input wire i_clk_sys,
  input wire i_rst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  // clock sources, asynchronous to i_clk_sys
  input wire i_aux_clk,
  input wire i_sub_main_clk,
  input wire i_main_clk,
  // keep-running requests to the clock system
  output reg o_keep_aux,
  output reg o_keep_sub_main,
  output reg o_keep_main,
  // processor events, same clock
  input wire i_global_interrupt_enable,
  input wire i_irq_accept,
  input wire i_return_from_interrupt,
  // processor flash read port
  input wire i_cpu_rd,
  input wire [15:0] i_cpu_addr,
  output reg [7:0] o_cpu_rdata,
  output reg o_cpu_hit,
  // flash array
  input wire [7:0] i_fl_rdata,
  output wire [15:0] o_fl_addr,
  output wire o_fl_rd,
  output reg [15:0] o_fl_op_addr,
  output reg [7:0] o_fl_wdata,
  output wire o_fl_prog,
  output wire o_fl_erase,
  output wire o_fl_margin0
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_SUSP = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`FPEC_C1_W-1:0] ctl1;
  reg [`FPEC_C2_W-1:0] ctl2;
  reg exit_bit;
  reg aborted;
  reg clk_fault;
  reg is_erase;
  reg [15:0] addr_reg;
  reg [7:0] data_reg;
  reg [`FPEC_TICK_W-1:0] tick_cnt;
  reg [`FPEC_TICK_W-1:0] next_tick_cnt;
  reg abort_now;
  reg done_now;
  reg start_now;

  wire tick;
  wire clk_stopped;
  wire busy;
  wire setup;
  wire wr_acc;
  wire wr_ctl1;
  wire wr_ctl3;
  wire in_info;
  wire in_main;
  wire irq_abort;
  wire irq_pause;
  wire [`FPEC_C3_W-1:0] ctl3_view;

  // zero-wait slave: every access ends in its first access cycle
  assign o_pready = 1'b1;
  assign setup = i_psel & ~i_penable;
  assign wr_acc = i_psel & i_penable & i_pwrite;
  assign wr_ctl1 = wr_acc & (i_paddr == `FPEC_OFF_CTL1);
  assign wr_ctl3 = wr_acc & (i_paddr == `FPEC_OFF_CTL3);

  // suspended counts as busy so software polling keeps waiting
  assign busy = state[1] | state[2]; // [R6]
  // array drive and busy come from the same state flops
  assign o_fl_prog = state[1] & ~is_erase; // [R14]
  assign o_fl_erase = state[1] & is_erase; // [R14]
  assign o_fl_margin0 = ctl1[`FPEC_C1_MARGIN0]; // [R12]

  assign ctl3_view = {state[2], clk_fault, aborted, exit_bit, busy};

  assign irq_abort = i_irq_accept & i_global_interrupt_enable &
                     ctl1[`FPEC_C1_ABORT_EN]; // [R4]
  // with the global enable low no return comes; software must force one
  assign irq_pause = i_irq_accept & is_erase &
                     ctl1[`FPEC_C1_SUSP_EN]; // [R5]

  fpec_tclk u_tclk (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_aux_clk(i_aux_clk),
    .i_sub_main_clk(i_sub_main_clk),
    .i_main_clk(i_main_clk),
    .i_sel(ctl2),
    .i_watch(state[1]),
    .o_tick(tick),
    .o_stopped(clk_stopped)
  );

  // apb read data and error, captured in the setup cycle
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_pslverr <= 1'b0;
      if (i_paddr == `FPEC_OFF_CTL1)
        o_prdata <= {{(32-`FPEC_C1_W){1'b0}}, ctl1};
      else if (i_paddr == `FPEC_OFF_CTL2)
        o_prdata <= {{(32-`FPEC_C2_W){1'b0}}, ctl2};
      else if (i_paddr == `FPEC_OFF_CTL3)
        o_prdata <= {{(32-`FPEC_C3_W){1'b0}}, ctl3_view}; // [R6]
      else if (i_paddr == `FPEC_OFF_ADDR)
        o_prdata <= {16'h0000, addr_reg};
      else if (i_paddr == `FPEC_OFF_DATA)
        o_prdata <= {24'h00_0000, data_reg};
      else begin
        o_prdata <= 32'h0000_0000;
        o_pslverr <= 1'b1;
      end
    end
  end

  // configuration registers; a busy block ignores new setups
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctl1 <= `FPEC_C1_RST;
      ctl2 <= `FPEC_C2_RST;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
    end else begin
      if (wr_ctl1 && !busy)
        ctl1 <= i_pwdata[`FPEC_C1_W-1:0];
      else if (done_now || abort_now)
        ctl1 <= ctl1 & ~(`FPEC_C1_RST | 5'h03);
      if (wr_acc && !busy && i_paddr == `FPEC_OFF_CTL2)
        ctl2 <= i_pwdata[`FPEC_C2_W-1:0]; // [R1]
      if (wr_acc && !busy && i_paddr == `FPEC_OFF_ADDR)
        addr_reg <= i_pwdata[15:0];
      if (wr_acc && !busy && i_paddr == `FPEC_OFF_DATA)
        data_reg <= i_pwdata[7:0];
    end
  end

  // exit bit is a level; while set no operation may start
  always @(posedge i_clk_sys) begin
    if (i_rst)
      exit_bit <= 1'b0;
    else if (wr_ctl3)
      exit_bit <= i_pwdata[`FPEC_C3_EXIT]; // [R3]
  end

  // sticky flags: hardware set wins over a write-one clear
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      aborted <= 1'b0;
      clk_fault <= 1'b0;
    end else begin
      if (abort_now)
        aborted <= 1'b1; // [R3] [R4] [R9]
      else if (wr_ctl3 && i_pwdata[`FPEC_C3_ABORTED])
        aborted <= 1'b0;
      if (state[1] && clk_stopped)
        clk_fault <= 1'b1; // [R9]
      else if (wr_ctl3 && i_pwdata[`FPEC_C3_CLK_FAULT])
        clk_fault <= 1'b0;
    end
  end

  // operation sequencer
  always @* begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    abort_now = 1'b0;
    done_now = 1'b0;
    start_now = 1'b0;
    case (state)
      ST_IDLE: begin
        if (wr_ctl1 && !exit_bit &&
            (i_pwdata[`FPEC_C1_ERASE] || i_pwdata[`FPEC_C1_WRITE])) begin
          start_now = 1'b1;
          next_state = ST_RUN;
          next_tick_cnt = {`FPEC_TICK_W{1'b0}};
        end
      end
      ST_RUN: begin
        if ((wr_ctl3 && i_pwdata[`FPEC_C3_EXIT]) || exit_bit) begin
          abort_now = 1'b1; // [R3]
          next_state = ST_IDLE;
        end else if (irq_abort) begin
          abort_now = 1'b1; // [R4]
          next_state = ST_IDLE;
        end else if (clk_stopped) begin
          abort_now = 1'b1; // [R9]
          next_state = ST_IDLE;
        end else if (irq_pause) begin
          next_state = ST_SUSP; // [R5]
        end else if (tick) begin
          if (tick_cnt == (is_erase ? `FPEC_ERASE_TICKS - 1'b1
                                    : `FPEC_WRITE_TICKS - 1'b1)) begin
            done_now = 1'b1; // [R14]
            next_state = ST_IDLE;
          end else begin
            next_tick_cnt = tick_cnt + 1'b1;
          end
        end
      end
      ST_SUSP: begin
        if ((wr_ctl3 && i_pwdata[`FPEC_C3_EXIT]) || exit_bit) begin
          abort_now = 1'b1; // [R3]
          next_state = ST_IDLE;
        end else if (i_return_from_interrupt) begin
          next_state = ST_RUN; // [R5]
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= ST_IDLE;
      tick_cnt <= {`FPEC_TICK_W{1'b0}};
      is_erase <= 1'b0;
      o_fl_op_addr <= 16'h0000;
      o_fl_wdata <= 8'h00;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      if (start_now) begin
        // erase has priority if both command bits are written
        is_erase <= i_pwdata[`FPEC_C1_ERASE];
        o_fl_op_addr <= addr_reg;
        o_fl_wdata <= data_reg;
      end
    end
  end

  // keep the chosen timing clock alive while the array is driven, except select 3 (runs on main) which raises no keep; a suspended erase drops it
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_keep_aux <= 1'b0;
      o_keep_sub_main <= 1'b0;
      o_keep_main <= 1'b0;
    end else begin
      o_keep_aux <= next_state[1] & (ctl2 == `FPEC_SEL_AUX); // [R2]
      o_keep_sub_main <= next_state[1] &
                         (ctl2 == `FPEC_SEL_SUB_MAIN); // [R2]
      o_keep_main <= next_state[1] & (ctl2 == `FPEC_SEL_MAIN); // [R2]
    end
  end

  // processor reads of the two flash regions
  assign in_info = (i_cpu_addr >= `FPEC_INFO_LO) &&
                   (i_cpu_addr <= `FPEC_INFO_HI); // [R7]
  assign in_main = (i_cpu_addr >= `FPEC_MAIN_LO) &&
                   (i_cpu_addr <= `FPEC_MAIN_HI); // [R8]
  // no array reads while the array is being driven
  assign o_fl_rd = i_cpu_rd & (in_info | in_main) & ~state[1];
  assign o_fl_addr = i_cpu_addr;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_cpu_rdata <= 8'h00;
      o_cpu_hit <= 1'b0;
    end else if (i_cpu_rd) begin
      o_cpu_hit <= o_fl_rd; // [R7] [R8]
      o_cpu_rdata <= o_fl_rd ? i_fl_rdata : 8'hff;
    end else begin
      o_cpu_hit <= 1'b0;
    end
  end

endmodule // fpec_ctrl

`default_nettype wire

// ### hdl/fpec_defs.vh
// constants of the flash program and erase controller
`ifndef FPEC_DEFS_VH
`define FPEC_DEFS_VH

// register byte offsets
`define FPEC_OFF_CTL1 12'h000
`define FPEC_OFF_CTL2 12'h004
`define FPEC_OFF_CTL3 12'h008
`define FPEC_OFF_ADDR 12'h00c
`define FPEC_OFF_DATA 12'h010

// flash_control_one fields
`define FPEC_C1_ERASE 0
`define FPEC_C1_WRITE 1
`define FPEC_C1_SUSP_EN 2
`define FPEC_C1_ABORT_EN 3
`define FPEC_C1_MARGIN0 4
`define FPEC_C1_W 5
`define FPEC_C1_RST 5'h00

// flash_control_two fields: timing clock select
`define FPEC_C2_W 2
`define FPEC_SEL_AUX 2'h0
`define FPEC_SEL_SUB_MAIN 2'h1
`define FPEC_SEL_MAIN 2'h2
`define FPEC_C2_RST 2'h2

// flash_control_three fields
`define FPEC_C3_BUSY 0
`define FPEC_C3_EXIT 1
`define FPEC_C3_ABORTED 2
`define FPEC_C3_CLK_FAULT 3
`define FPEC_C3_SUSPENDED 4
`define FPEC_C3_W 5

// flash address regions
`define FPEC_INFO_LO 16'h1080
`define FPEC_INFO_HI 16'h10ff
`define FPEC_MAIN_LO 16'hc000
`define FPEC_MAIN_HI 16'hffff

// operation lengths in timing clock ticks
`define FPEC_TICK_W 13
`define FPEC_WRITE_TICKS 13'h0020
`define FPEC_ERASE_TICKS 13'h1000

// system cycles without a timing edge that count as a stopped clock
`define FPEC_STOP_W 8
`define FPEC_STOP_CYC 8'hc8

`endif

// ### hdl/fpec_tclk.v
// timing clock selection, edge ticks and stop detection
`timescale 1ns/10ps
`default_nettype none
`include "fpec_defs.vh"

module fpec_tclk (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_aux_clk,
  input wire i_sub_main_clk,
  input wire i_main_clk,
  input wire [1:0] i_sel,
  input wire i_watch,
  output wire o_tick,
  output reg o_stopped
);

  reg [2:0] sync_a;
  reg [2:0] sync_b;
  reg sel_q;
  reg sel_prev;
  reg [`FPEC_STOP_W-1:0] idle_cnt;
  wire [2:0] raw;

  assign raw = {i_main_clk, i_sub_main_clk, i_aux_clk};

  // clocks from other domains: two flops before any use
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always @(posedge i_clk_sys) begin
        if (i_rst) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= raw[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      sel_q <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      if (i_sel == `FPEC_SEL_AUX) // [R1]
        sel_q <= sync_b[0];
      else if (i_sel == `FPEC_SEL_SUB_MAIN) // [R1]
        sel_q <= sync_b[1];
      else
        sel_q <= sync_b[2]; // [R1]
      sel_prev <= sel_q;
    end
  end

  assign o_tick = sel_q & ~sel_prev;

  // a crystal fault shows only as missing edges
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      idle_cnt <= {`FPEC_STOP_W{1'b0}};
      o_stopped <= 1'b0;
    end else if (!i_watch || o_tick) begin
      idle_cnt <= {`FPEC_STOP_W{1'b0}};
      o_stopped <= 1'b0;
    end else if (idle_cnt == `FPEC_STOP_CYC) begin
      o_stopped <= 1'b1; // [R9]
    end else begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

endmodule // fpec_tclk

`default_nettype wire

// ### tb/fpec_flash_model.sv
// flash array and timing clock sources
`timescale 1ns/10ps
`default_nettype none
module fpec_flash_model (
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic i_stop_aux,
  output logic [7:0] o_rdata,
  output logic o_aux,
  output logic o_sub,
  output logic o_main
);
  wire [7:0] pat = i_addr[7:0] ^ i_addr[15:8];
  initial begin
    o_aux = 1'h0;
    o_sub = 1'h0;
    o_main = 1'h0;
  end
  // three unrelated timing clocks
  always #251 o_sub = !o_sub;
  always #149 o_main = !o_main;
  // a failed crystal freezes the aux clock
  always #347 if (!i_stop_aux) o_aux = !o_aux;
  // unread array shows inverted data, never a stale byte
  assign o_rdata = i_rd ? pat : ~pat;
endmodule // fpec_flash_model
`default_nettype wire

// ### tb/fpec_sva.sv
// port assertions of the flash controller
`timescale 1ns/10ps
`default_nettype none
module fpec_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_keep_aux,
  input wire logic o_keep_sub_main,
  input wire logic o_keep_main,
  input wire logic i_global_interrupt_enable,
  input wire logic i_irq_accept,
  input wire logic i_cpu_rd,
  input wire logic [15:0] i_cpu_addr,
  input wire logic o_cpu_hit,
  input wire logic [7:0] o_cpu_rdata,
  input wire logic [7:0] i_fl_rdata,
  input wire logic o_fl_prog,
  input wire logic o_fl_erase,
  input wire logic o_fl_margin0
);
  logic ex;
  logic ab;
  wire run = o_fl_prog | o_fl_erase;
  wire acc = i_psel & i_penable & i_pwrite;
  wire w1 = acc & (i_paddr == 12'h000) & !run;
  wire inr = i_cpu_addr >= 16'hc000 ||
    (i_cpu_addr >= 16'h1080 && i_cpu_addr <= 16'h10ff);
  // shadow copies of exit level and abort enable
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      ex <= 1'h0;
      ab <= 1'h0;
    end else begin
      if (acc && i_paddr == 12'h008)
        ex <= i_pwdata[1];
      if (w1)
        ab <= i_pwdata[3];
    end
  end
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  AST_KEEP: assert property (
    run == (o_keep_aux | o_keep_sub_main | o_keep_main))
    else $error("keep request differs from activity");
  AST_START: assert property (
    w1 && !ex && i_pwdata[1:0] != 2'h0 |=>
    run && o_fl_erase == $past(i_pwdata[0]))
    else $error("operation did not start");
  AST_REFUSE: assert property (w1 && ex |=> !run)
    else $error("start taken while exit set");
  AST_EXIT: assert property (
    acc && i_paddr == 12'h008 && i_pwdata[1] && run |=> !run)
    else $error("exit did not stop operation");
  AST_IRQ: assert property (
    i_irq_accept && i_global_interrupt_enable && ab && run |=> !run)
    else $error("interrupt did not abort");
  AST_HIT: assert property (
    i_cpu_rd && !run && inr |=>
    o_cpu_hit && o_cpu_rdata == $past(i_fl_rdata))
    else $error("flash region read failed");
  AST_MISS: assert property (
    i_cpu_rd && (run || !inr) |=> !o_cpu_hit && o_cpu_rdata == 8'hff)
    else $error("read hit outside region");
  AST_MARGIN: assert property (
    w1 |=> o_fl_margin0 == $past(i_pwdata[4]))
    else $error("margin mode not taken");
endmodule // fpec_sva
`default_nettype wire

// ### tb/tb_fpec_ctrl.sv
// self-checking bench of the flash controller
`timescale 1ns/10ps
`default_nettype none
module tb_fpec_ctrl;
  logic i_clk_sys = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0;
  logic i_pwrite = 1'h0, i_irq_accept = 1'h0, i_cpu_rd = 1'h0;
  logic i_global_interrupt_enable = 1'h0, i_return_from_interrupt = 1'h0;
  logic stop = 1'h0, cpu_q = 1'h0;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic [15:0] i_cpu_addr = 16'h0;
  wire o_pready, o_pslverr, o_cpu_hit, o_keep_aux, o_keep_sub_main;
  wire o_keep_main, o_fl_rd, o_fl_prog, o_fl_erase, o_fl_margin0;
  wire i_aux_clk, i_sub_main_clk, i_main_clk;
  wire [31:0] o_prdata;
  wire [7:0] o_cpu_rdata, i_fl_rdata, o_fl_wdata;
  wire [15:0] o_fl_addr, o_fl_op_addr;
  logic [63:0] q[$];
  int miscompares = 0, n_tests = 0, cyc = 0;
  fpec_ctrl dut (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_aux_clk,
    .i_sub_main_clk, .i_main_clk, .o_keep_aux, .o_keep_sub_main,
    .o_keep_main, .i_global_interrupt_enable, .i_irq_accept,
    .i_return_from_interrupt, .i_cpu_rd, .i_cpu_addr, .o_cpu_rdata,
    .o_cpu_hit, .i_fl_rdata, .o_fl_addr, .o_fl_rd, .o_fl_op_addr,
    .o_fl_wdata, .o_fl_prog, .o_fl_erase, .o_fl_margin0);
  fpec_flash_model far (.i_rd(o_fl_rd), .i_addr(o_fl_addr),
    .i_stop_aux(stop), .o_rdata(i_fl_rdata), .o_aux(i_aux_clk),
    .o_sub(i_sub_main_clk), .o_main(i_main_clk));
  always #50 i_clk_sys = !i_clk_sys;
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [63:0] e);
    n_tests++;
    if ((got & e[63:32]) !== e[31:0]) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got,
        e[31:0]);
    end
  endtask
  // results are matched in issue order
  always @(posedge i_clk_sys) begin
    cpu_q <= i_cpu_rd;
    cyc <= cyc + 1;
    if (cpu_q)
      chk({23'h0, o_cpu_hit, o_cpu_rdata}, q.pop_front());
    else if (i_psel && i_penable && o_pready === 1'h1 && !i_pwrite)
      chk(o_prdata, q.pop_front());
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'h1;
    @(posedge i_clk_sys);
    while (o_pready !== 1'h1)
      @(posedge i_clk_sys);
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
    q.push_back({m, e});
    apb(1'h0, a, 32'h0);
  endtask
  task automatic cpu(input logic [15:0] a, input logic [8:0] e);
    q.push_back({32'h1ff, 23'h0, e});
    i_cpu_rd <= 1'h1;
    i_cpu_addr <= a;
    @(posedge i_clk_sys);
    i_cpu_rd <= 1'h0;
    @(posedge i_clk_sys);
  endtask
  task automatic irq(input logic g);
    i_global_interrupt_enable <= g;
    i_irq_accept <= 1'h1;
    @(posedge i_clk_sys);
    i_irq_accept <= 1'h0;
  endtask
  // bounded wait for the array to be released
  task automatic idle(input int n);
    for (int k = 0; k < n && (o_fl_prog | o_fl_erase); k++)
      @(negedge i_clk_sys);
    chk({31'h0, o_fl_prog | o_fl_erase}, {32'h1, 32'h0});
    @(posedge i_clk_sys);
  endtask
  initial begin
    logic [15:0] ad[8] = '{16'h107f, 16'h1080, 16'h10ff, 16'h1100,
      16'hbfff, 16'hc000, 16'hffff, 16'h0000};
    logic [31:0] rv;
    rv = $urandom(82644);
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    @(posedge i_clk_sys);
    for (int k = 0; k < 6; k++)
      rd(12'(k * 4), 32'hffffffff, k == 1 ? 32'h2 : 32'h0);
    // last read hit the unmapped word, so the error flag must stand
    chk({31'h0, o_pslverr}, {32'h1, 32'h1});
    rv = $urandom();
    wr(12'h00c, rv);
    wr(12'h010, rv);
    rd(12'h00c, 32'hffffffff, {16'h0, rv[15:0]});
    rd(12'h010, 32'hffffffff, {24'h0, rv[7:0]});
    for (int s = 0; s < 3; s++) begin
      wr(12'h004, 32'(s));
      wr(12'h000, 32'h2);
      rd(12'h008, 32'h1f, 32'h1);
      @(negedge i_clk_sys);
      chk({o_keep_main, o_keep_sub_main, o_keep_aux},
        {32'h7, 32'h1 << s});
      // operands are latched at start from the staged words
      chk({8'h0, o_fl_op_addr, o_fl_wdata},
        {32'hffffff, 8'h0, rv[15:0], rv[7:0]});
      idle(400);
      rd(12'h008, 32'h1f, 32'h0);
    end
    wr(12'h000, 32'h1);
    wr(12'h008, 32'h2);
    idle(2);
    rd(12'h008, 32'h1b, 32'h2);
    wr(12'h000, 32'h2);
    idle(2);
    wr(12'h008, 32'hc);
    wr(12'h000, 32'ha);
    irq(1'h0);
    rd(12'h008, 32'h1, 32'h1);
    irq(1'h1);
    idle(2);
    rd(12'h008, 32'h5, 32'h4);
    wr(12'h008, 32'hc);
    wr(12'h000, 32'h5);
    irq(1'h0);
    idle(2);
    rd(12'h008, 32'h1f, 32'h11);
    i_return_from_interrupt <= 1'h1;
    @(posedge i_clk_sys);
    i_return_from_interrupt <= 1'h0;
    rd(12'h008, 32'h1f, 32'h1);
    wr(12'h008, 32'h2);
    wr(12'h008, 32'hc);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h2);
    stop <= 1'h1;
    cpu(16'hc000, 9'h0ff);
    idle(300);
    rd(12'h008, 32'h9, 32'h8);
    stop <= 1'h0;
    wr(12'h008, 32'hc);
    rv = {$urandom()} | 32'hc000;
    cpu(rv[15:0], {1'h1, rv[7:0] ^ rv[15:8]});
    foreach (ad[k])
      cpu(ad[k], (ad[k] >= 16'hc000 || (ad[k] >= 16'h1080 &&
        ad[k] <= 16'h10ff)) ? {1'h1, ad[k][7:0] ^ ad[k][15:8]} :
        9'h0ff);
    wr(12'h000, 32'h10);
    rd(12'h000, 32'h1f, 32'h10);
    summarize();
  end
endmodule // tb_fpec_ctrl
bind fpec_ctrl fpec_sva u_sva (.i_clk_sys, .i_rst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_keep_aux, .o_keep_sub_main,
  .o_keep_main, .i_global_interrupt_enable, .i_irq_accept, .i_cpu_rd,
  .i_cpu_addr, .o_cpu_hit, .o_cpu_rdata, .i_fl_rdata, .o_fl_prog,
  .o_fl_erase, .o_fl_margin0);
`default_nettype wire
